// [src/sfif_pkg.sv]
// Constants, opcodes and state codes of the serial flash instruction front end.
package sfif_pkg;

  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_VWREN   = 8'h50;
  localparam logic [7:0] OP_WRDI    = 8'h04;
  localparam logic [7:0] OP_RDSTLO  = 8'h05;
  localparam logic [7:0] OP_RDSTHI  = 8'h35;
  localparam logic [7:0] OP_WRST    = 8'h01;
  localparam logic [7:0] OP_PROG    = 8'h02;
  localparam logic [7:0] OP_QPROG   = 8'h32;
  localparam logic [7:0] OP_ER4K    = 8'h20;
  localparam logic [7:0] OP_ER32K   = 8'h52;
  localparam logic [7:0] OP_ER64K   = 8'hD8;
  localparam logic [7:0] OP_ERCHIPA = 8'hC7;
  localparam logic [7:0] OP_ERCHIPB = 8'h60;
  localparam logic [7:0] OP_SUSP    = 8'h75;
  localparam logic [7:0] OP_RESUME  = 8'h7A;
  localparam logic [7:0] OP_PWRDN   = 8'hB9;
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_FREAD   = 8'h0B;
  localparam logic [7:0] OP_DOREAD  = 8'h3B;
  localparam logic [7:0] OP_QOREAD  = 8'h6B;
  localparam logic [7:0] OP_DIOREAD = 8'hBB;
  localparam logic [7:0] OP_QIOREAD = 8'hEB;
  localparam logic [7:0] OP_WQREAD  = 8'hE7;
  localparam logic [7:0] OP_OWQREAD = 8'hE3;

  // Address phase length in link clocks, per lane count
  localparam logic [5:0] ADDR_CLK_X1 = 6'h18;
  localparam logic [5:0] ADDR_CLK_X2 = 6'h10;
  localparam logic [5:0] ADDR_CLK_X4 = 6'h08;
  // Dummy clocks
  localparam logic [3:0] DUMMY_BYTE  = 4'h8;
  localparam logic [3:0] DUMMY_EB    = 4'h4;
  localparam logic [3:0] DUMMY_E7    = 4'h2;
  localparam logic [3:0] DUMMY_NONE  = 4'h0;
  // Address bytes that an addressed write carries
  localparam logic [3:0] ADDR_BYTES  = 4'h3;
  localparam logic [3:0] BYTE_CNT_MAX = 4'hF;

  typedef enum logic [2:0] {
    ST_OPC    = 3'b000,
    ST_ADDR   = 3'b001,
    ST_DUMMY  = 3'b010,
    ST_DOUT   = 3'b011,
    ST_DIN    = 3'b100,
    ST_STAT   = 3'b101,
    ST_DONE   = 3'b110,
    ST_IGNORE = 3'b111
  } sfif_state_type;

endpackage : sfif_pkg

// [src/sfif_frontend.sv]
// Serial flash instruction framing, decode and lane handling with clock-domain crossing.
`timescale 1ns/100ps
module sfif_frontend (
  // System clock domain
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Serial link pins
  input  wire logic        serialClk,
  input  wire logic        selectPin_n,
  input  wire logic [3:0]  laneIn,
  output logic      [3:0]  laneOut,
  output logic      [3:0]  laneOe,
  // Device state from the array engines
  input  wire logic [7:0]  statusLowByte,
  input  wire logic [7:0]  statusHighByte,
  input  wire logic        busyIn,
  input  wire logic        cycleDone,
  // Protection query
  output logic [23:0]      checkAddr,
  output logic [7:0]       checkOp,
  input  wire logic        protectHit,
  // Read data fetch
  output logic             fetchReq,
  output logic [23:0]      fetchAddr,
  input  wire logic [7:0]  fetchData,
  input  wire logic        fetchValid,
  // Program data stream
  output logic             progValid,
  output logic [7:0]       progByte,
  // Accepted commands
  output logic             cmdValid,
  output logic [7:0]       cmdOp,
  output logic [23:0]      cmdAddr,
  output logic             cmdVolatile,
  output logic [7:0]       statusWrLow,
  output logic [7:0]       statusWrHigh,
  output logic [1:0]       statusWrBytes,
  output logic             cmdDrop,
  output logic             writeLatchFlag
);

  // Shift in one, two or four lanes, highest bit first
  function automatic logic [31:0] shiftIn(input logic [31:0] sh, input logic [2:0] lanes, input logic [3:0] pins);
    unique case (lanes)
      3'd1:    shiftIn = {sh[30:0], pins[0]};
      3'd2:    shiftIn = {sh[29:0], pins[1:0]};
      default: shiftIn = {sh[27:0], pins[3:0]};
    endcase
  endfunction : shiftIn

  // Lane values for a byte at bit position pos
  function automatic logic [3:0] laneBits(input logic [7:0] b, input logic [2:0] pos, input logic [2:0] lanes);
    logic [7:0] s;
    s = 8'(b << pos);
    unique case (lanes)
      3'd1:    laneBits = {2'b00, s[7], 1'b0};
      3'd2:    laneBits = {2'b00, s[7:6]};
      default: laneBits = s[7:4];
    endcase
  endfunction : laneBits

  function automatic logic [3:0] laneEnable(input logic [2:0] lanes);
    unique case (lanes)
      3'd1:    laneEnable = 4'h2;
      3'd2:    laneEnable = 4'h3;
      default: laneEnable = 4'hF;
    endcase
  endfunction : laneEnable

  // ---------------- Link domain ----------------
  // Frame logic is held in reset while deselected
  logic linkRst_n;
  assign linkRst_n = arst_n & ~selectPin_n;

  sfif_pkg::sfif_state_type state_r;
  logic [2:0]  bitCnt_r;
  logic [6:0]  opSh_r;
  logic [5:0]  clkCnt_r;
  logic [5:0]  addrClk_r;
  logic [2:0]  addrLanes_r;
  logic [3:0]  dummy_r;
  logic [2:0]  lanes_r;
  logic        isRead_r;
  logic        statHigh_r;
  logic [31:0] addrSh_r;
  logic [2:0]  pos_r;
  logic [7:0]  dinSh_r;
  logic        busyL1_r;
  logic        busyL2_r;

  // Frame record, survives deselect for the system side
  logic [7:0]  recOp_r;
  logic        recOk_r;
  logic [23:0] recAddr_r;
  logic [2:0]  recBits_r;
  logic [3:0]  recBytes_r;
  logic [23:0] lnkFetchAddr_r;
  logic        fetchTgl_r;
  logic [7:0]  dinByte_r;
  logic        dinTgl_r;

  // Opcode decode
  logic [7:0] opNow;
  logic       dKnown;
  logic       dStat;
  logic       dRead;
  logic       dDin;
  logic [5:0] dAddrClk;
  logic [3:0] dDummy;
  logic [2:0] dLanes;
  assign opNow = {opSh_r, laneIn[0]};

  always_comb begin
    dKnown   = 1'b1;
    dStat    = 1'b0;
    dRead    = 1'b0;
    dDin     = 1'b0;
    dAddrClk = 6'h00;
    dDummy   = sfif_pkg::DUMMY_NONE;
    dLanes   = 3'd1;
    unique case (opNow)
      sfif_pkg::OP_WREN, sfif_pkg::OP_VWREN, sfif_pkg::OP_WRDI,
      sfif_pkg::OP_SUSP, sfif_pkg::OP_RESUME, sfif_pkg::OP_PWRDN,
      sfif_pkg::OP_ERCHIPA, sfif_pkg::OP_ERCHIPB: dKnown = 1'b1;
      sfif_pkg::OP_RDSTLO, sfif_pkg::OP_RDSTHI: dStat = 1'b1;
      sfif_pkg::OP_WRST: dDin = 1'b1;
      sfif_pkg::OP_PROG: begin
        dDin     = 1'b1;
        dAddrClk = sfif_pkg::ADDR_CLK_X1;
      end
      sfif_pkg::OP_QPROG: begin
        dDin     = 1'b1;
        dAddrClk = sfif_pkg::ADDR_CLK_X1;
        dLanes   = 3'd4;
      end
      sfif_pkg::OP_ER4K, sfif_pkg::OP_ER32K, sfif_pkg::OP_ER64K: dAddrClk = sfif_pkg::ADDR_CLK_X1;
      sfif_pkg::OP_READ: begin
        dRead    = 1'b1;
        dAddrClk = sfif_pkg::ADDR_CLK_X1;
      end
      sfif_pkg::OP_FREAD, sfif_pkg::OP_DOREAD, sfif_pkg::OP_QOREAD: begin
        dRead    = 1'b1;
        dAddrClk = sfif_pkg::ADDR_CLK_X1;
        dDummy   = sfif_pkg::DUMMY_BYTE;
        dLanes   = (opNow == sfif_pkg::OP_FREAD) ? 3'd1 : (opNow == sfif_pkg::OP_DOREAD) ? 3'd2 : 3'd4;
      end
      sfif_pkg::OP_DIOREAD: begin
        dRead    = 1'b1;
        dAddrClk = sfif_pkg::ADDR_CLK_X2;
        dLanes   = 3'd2;
      end
      sfif_pkg::OP_QIOREAD, sfif_pkg::OP_WQREAD, sfif_pkg::OP_OWQREAD: begin
        dRead    = 1'b1;
        dAddrClk = sfif_pkg::ADDR_CLK_X4;
        dLanes   = 3'd4;
        dDummy   = (opNow == sfif_pkg::OP_QIOREAD) ? sfif_pkg::DUMMY_EB :
                   (opNow == sfif_pkg::OP_WQREAD) ? sfif_pkg::DUMMY_E7 :
                   sfif_pkg::DUMMY_NONE;
      end
      default: dKnown = 1'b0;
    endcase
  end

  // Busy level into the link domain
  always_ff @(posedge serialClk or negedge arst_n) begin
    if (!arst_n) begin
      busyL1_r <= 1'b0;
      busyL2_r <= 1'b0;
    end else begin
      busyL1_r <= busyIn;
      busyL2_r <= busyL1_r;
    end
  end

  logic [31:0] addrShNxt;
  logic [23:0] addrNow;
  logic [2:0]  posNxt;
  logic [7:0]  dinShNxt;
  assign addrShNxt = shiftIn(addrSh_r, addrLanes_r, laneIn);
  assign addrNow   = (addrLanes_r == 3'd1) ? addrShNxt[23:0] : addrShNxt[31:8];
  assign posNxt    = 3'(pos_r + lanes_r);
  assign dinShNxt  = 8'(shiftIn({24'h000000, dinSh_r}, lanes_r, laneIn));

  // Frame sequencer
  always_ff @(posedge serialClk or negedge linkRst_n) begin
    if (!linkRst_n) begin
      state_r     <= sfif_pkg::ST_OPC;
      bitCnt_r    <= 3'd0;
      opSh_r      <= 7'h00;
      clkCnt_r    <= 6'h00;
      addrClk_r   <= 6'h00;
      addrLanes_r <= 3'd1;
      dummy_r     <= 4'h0;
      lanes_r     <= 3'd1;
      isRead_r    <= 1'b0;
      statHigh_r  <= 1'b0;
      addrSh_r    <= 32'h00000000;
      pos_r       <= 3'd0;
      dinSh_r     <= 8'h00;
    end else begin
      unique case (state_r)
        sfif_pkg::ST_OPC: begin
          opSh_r   <= {opSh_r[5:0], laneIn[0]};
          bitCnt_r <= 3'(bitCnt_r + 3'd1);
          if (bitCnt_r == 3'd7) begin
            addrClk_r   <= dAddrClk;
            addrLanes_r <= (dAddrClk == sfif_pkg::ADDR_CLK_X2) ? 3'd2 :
                           (dAddrClk == sfif_pkg::ADDR_CLK_X4) ? 3'd4 : 3'd1;
            dummy_r     <= dDummy;
            lanes_r     <= dLanes;
            isRead_r    <= dRead;
            statHigh_r  <= (opNow == sfif_pkg::OP_RDSTHI);
            if (!dKnown || (busyL2_r && !dStat))
              state_r <= sfif_pkg::ST_IGNORE;
            else if (dStat)
              state_r <= sfif_pkg::ST_STAT;
            else if (dAddrClk != 6'h00)
              state_r <= sfif_pkg::ST_ADDR;
            else if (dDin)
              state_r <= sfif_pkg::ST_DIN;
            else
              state_r <= sfif_pkg::ST_DONE;
          end
        end
        sfif_pkg::ST_ADDR: begin
          addrSh_r <= addrShNxt;
          clkCnt_r <= 6'(clkCnt_r + 6'h01);
          if (clkCnt_r == 6'(addrClk_r - 6'h01)) begin
            clkCnt_r <= 6'h00;
            if (isRead_r)
              state_r <= (dummy_r != 4'h0) ? sfif_pkg::ST_DUMMY : sfif_pkg::ST_DOUT;
            else if (lanes_r == 3'd4 || recOp_r == sfif_pkg::OP_PROG)
              state_r <= sfif_pkg::ST_DIN;
            else
              state_r <= sfif_pkg::ST_DONE;
          end
        end
        sfif_pkg::ST_DUMMY: begin
          clkCnt_r <= 6'(clkCnt_r + 6'h01);
          if (clkCnt_r == 6'({2'b00, dummy_r} - 6'h01))
            state_r <= sfif_pkg::ST_DOUT;
        end
        sfif_pkg::ST_DOUT, sfif_pkg::ST_STAT: begin
          pos_r <= posNxt;
        end
        sfif_pkg::ST_DIN: begin
          pos_r   <= posNxt;
          dinSh_r <= dinShNxt;
        end
        sfif_pkg::ST_DONE, sfif_pkg::ST_IGNORE: begin
          pos_r <= pos_r;
        end
      endcase
    end
  end

  // Frame record and events for the system side
  logic frameFirst;
  logic opDone;
  assign frameFirst = (state_r == sfif_pkg::ST_OPC) && (bitCnt_r == 3'd0);
  assign opDone     = (state_r == sfif_pkg::ST_OPC) && (bitCnt_r == 3'd7);

  always_ff @(posedge serialClk or negedge arst_n) begin
    if (!arst_n) begin
      recOp_r        <= 8'h00;
      recOk_r        <= 1'b0;
      recAddr_r      <= 24'h000000;
      recBits_r      <= 3'd0;
      recBytes_r     <= 4'h0;
      lnkFetchAddr_r <= 24'h000000;
      fetchTgl_r     <= 1'b0;
      dinByte_r      <= 8'h00;
      dinTgl_r       <= 1'b0;
    end else begin
      if (frameFirst) begin
        recOk_r    <= 1'b0;
        recBits_r  <= 3'd1;
        recBytes_r <= 4'h0;
      end else begin
        recBits_r <= (state_r == sfif_pkg::ST_DIN && lanes_r == 3'd4) ? 3'(recBits_r + 3'd4) :
                     3'(recBits_r + 3'd1);
        if (recBits_r == 3'd0 && recBytes_r != sfif_pkg::BYTE_CNT_MAX)
          recBytes_r <= 4'(recBytes_r + 4'h1);
      end
      if (opDone) begin
        recOp_r <= opNow;
        recOk_r <= dKnown && (!busyL2_r || dStat);
      end
      if (state_r == sfif_pkg::ST_ADDR && clkCnt_r == 6'(addrClk_r - 6'h01)) begin
        recAddr_r <= addrNow;
        if (isRead_r) begin
          lnkFetchAddr_r <= addrNow;
          fetchTgl_r     <= ~fetchTgl_r;
        end
      end
      // Next byte requested once the current one is latched
      if (state_r == sfif_pkg::ST_DOUT && pos_r == 3'd0) begin
        lnkFetchAddr_r <= 24'(lnkFetchAddr_r + 24'h000001);
        fetchTgl_r     <= ~fetchTgl_r;
      end
      if (state_r == sfif_pkg::ST_DIN && posNxt == 3'd0) begin
        dinByte_r <= dinShNxt;
        dinTgl_r  <= ~dinTgl_r;
      end
    end
  end

  // Output lanes change on falling edges
  logic [7:0] statShadowLo_r;
  logic [7:0] statShadowHi_r;
  logic [7:0] fetchHold_r;
  logic [7:0] curByte_r;
  logic [7:0] srcByte;
  logic       driving;
  assign driving = (state_r == sfif_pkg::ST_DOUT) || (state_r == sfif_pkg::ST_STAT);
  assign srcByte = (pos_r != 3'd0) ? curByte_r :
                   (state_r == sfif_pkg::ST_STAT) ? (statHigh_r ? statShadowHi_r : statShadowLo_r) :
                   fetchHold_r;

  always_ff @(negedge serialClk or negedge linkRst_n) begin
    if (!linkRst_n) begin
      curByte_r <= 8'h00;
      laneOut   <= 4'h0;
      laneOe    <= 4'h0;
    end else if (driving) begin
      curByte_r <= srcByte;
      laneOut   <= laneBits(srcByte, pos_r, (state_r == sfif_pkg::ST_STAT) ? 3'd1 : lanes_r);
      laneOe    <= laneEnable((state_r == sfif_pkg::ST_STAT) ? 3'd1 : lanes_r);
    end else begin
      curByte_r <= curByte_r;
      laneOut   <= 4'h0;
      laneOe    <= 4'h0;
    end
  end

  // ---------------- System domain ----------------
  logic selS1_r;
  logic selS2_r;
  logic selS3_r;
  logic fetS1_r;
  logic fetS2_r;
  logic fetS3_r;
  logic dinS1_r;
  logic dinS2_r;
  logic dinS3_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      selS1_r <= 1'b1;
      selS2_r <= 1'b1;
      selS3_r <= 1'b1;
      fetS1_r <= 1'b0;
      fetS2_r <= 1'b0;
      fetS3_r <= 1'b0;
      dinS1_r <= 1'b0;
      dinS2_r <= 1'b0;
      dinS3_r <= 1'b0;
    end else begin
      selS1_r <= selectPin_n;
      selS2_r <= selS1_r;
      selS3_r <= selS2_r;
      fetS1_r <= fetchTgl_r;
      fetS2_r <= fetS1_r;
      fetS3_r <= fetS2_r;
      dinS1_r <= dinTgl_r;
      dinS2_r <= dinS1_r;
      dinS3_r <= dinS2_r;
    end
  end

  logic frameEnd;
  logic frameStart;
  logic fetchEvt;
  logic dinEvt;
  assign frameEnd   = selS2_r & ~selS3_r;
  assign frameStart = ~selS2_r & selS3_r;
  assign fetchEvt   = fetS2_r ^ fetS3_r;
  assign dinEvt     = dinS2_r ^ dinS3_r;

  // Status frozen while selected, read data held for the link
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      statShadowLo_r <= 8'h00;
      statShadowHi_r <= 8'h00;
      fetchHold_r    <= 8'h00;
      fetchReq       <= 1'b0;
      fetchAddr      <= 24'h000000;
    end else begin
      if (selS2_r) begin
        statShadowLo_r <= statusLowByte;
        statShadowHi_r <= statusHighByte;
      end
      if (fetchValid)
        fetchHold_r <= fetchData;
      fetchReq <= fetchEvt;
      if (fetchEvt)
        fetchAddr <= lnkFetchAddr_r;
    end
  end

  // Data bytes of program and status write
  logic       writeOp;
  logic [1:0] dinIdx_r;
  logic       volEn_r;
  assign writeOp = (recOp_r == sfif_pkg::OP_PROG) || (recOp_r == sfif_pkg::OP_QPROG);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      progValid     <= 1'b0;
      progByte      <= 8'h00;
      dinIdx_r      <= 2'd0;
      statusWrLow   <= 8'h00;
      statusWrHigh  <= 8'h00;
      statusWrBytes <= 2'd0;
    end else begin
      progValid <= dinEvt && writeOp && recOk_r && writeLatchFlag && !busyIn;
      if (dinEvt)
        progByte <= dinByte_r;
      if (frameStart) begin
        dinIdx_r      <= 2'd0;
        statusWrBytes <= 2'd0;
      end else if (dinEvt && recOp_r == sfif_pkg::OP_WRST && dinIdx_r != 2'd2) begin
        dinIdx_r      <= 2'(dinIdx_r + 2'd1);
        statusWrBytes <= 2'(dinIdx_r + 2'd1);
        if (dinIdx_r == 2'd0)
          statusWrLow <= dinByte_r;
        else
          statusWrHigh <= dinByte_r;
      end
    end
  end

  // Dispatch: protection query, then accept or drop
  logic pend_r;
  logic aligned;
  logic isErase;
  logic needLatch;
  logic accept;
  assign aligned   = (recBits_r == 3'd0);
  assign isErase   = (checkOp == sfif_pkg::OP_ER4K) || (checkOp == sfif_pkg::OP_ER32K) ||
                     (checkOp == sfif_pkg::OP_ER64K);
  assign needLatch = isErase || (checkOp == sfif_pkg::OP_PROG) || (checkOp == sfif_pkg::OP_QPROG) ||
                     (checkOp == sfif_pkg::OP_ERCHIPA) || (checkOp == sfif_pkg::OP_ERCHIPB);

  always_comb begin
    accept = 1'b0;
    if (recOk_r && !busyIn) begin
      if (needLatch)
        accept = aligned && writeLatchFlag && !protectHit &&
                 (isErase ? (recBytes_r == sfif_pkg::ADDR_BYTES) :
                  (checkOp == sfif_pkg::OP_ERCHIPA || checkOp == sfif_pkg::OP_ERCHIPB) ? (recBytes_r == 4'h0) :
                  (recBytes_r > sfif_pkg::ADDR_BYTES));
      else if (checkOp == sfif_pkg::OP_WRST)
        accept = aligned && (recBytes_r != 4'h0) && (writeLatchFlag || volEn_r);
      else if (checkOp == sfif_pkg::OP_SUSP || checkOp == sfif_pkg::OP_RESUME || checkOp == sfif_pkg::OP_PWRDN)
        accept = aligned && (recBytes_r == 4'h0);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_r    <= 1'b0;
      checkAddr <= 24'h000000;
      checkOp   <= 8'h00;
    end else begin
      pend_r <= frameEnd;
      if (frameEnd) begin
        checkAddr <= recAddr_r;
        checkOp   <= recOp_r;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmdValid    <= 1'b0;
      cmdOp       <= 8'h00;
      cmdAddr     <= 24'h000000;
      cmdVolatile <= 1'b0;
      cmdDrop     <= 1'b0;
    end else begin
      cmdValid <= pend_r && accept;
      cmdDrop  <= pend_r && !accept && (needLatch || checkOp == sfif_pkg::OP_WRST);
      if (pend_r && accept) begin
        cmdOp       <= checkOp;
        cmdAddr     <= checkAddr;
        cmdVolatile <= (checkOp == sfif_pkg::OP_WRST) && volEn_r;
      end
    end
  end

  // Write latch and volatile enable; a set beats a completion clear
  logic wrenHit;
  assign wrenHit = pend_r && recOk_r && !busyIn && aligned && (recBytes_r == 4'h0);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      writeLatchFlag <= 1'b0;
      volEn_r        <= 1'b0;
    end else begin
      if (cycleDone)
        writeLatchFlag <= 1'b0;
      if (pend_r && accept && checkOp == sfif_pkg::OP_WRST)
        volEn_r <= 1'b0;
      if (wrenHit && checkOp == sfif_pkg::OP_WRDI) begin
        writeLatchFlag <= 1'b0;
        volEn_r        <= 1'b0;
      end
      if (wrenHit && checkOp == sfif_pkg::OP_VWREN)
        volEn_r <= 1'b1;
      if (wrenHit && checkOp == sfif_pkg::OP_WREN)
        writeLatchFlag <= 1'b1;
    end
  end

endmodule : sfif_frontend

// [dv/sfif_frontend_assertions.sv]
// Port checker of the instruction front end.
`timescale 1ns/100ps
module sfif_frontend_assertions (
  // Clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // Watched ports
  input wire logic       selectPin_n,
  input wire logic [3:0] laneOe,
  input wire logic       fetchReq,
  input wire logic       cmdValid,
  input wire logic       cmdDrop,
  input wire logic       cycleDone,
  input wire logic       writeLatchFlag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_end;
    $rose(selectPin_n);
  endsequence
  sequence s_cmd;
    cmdValid || cmdDrop;
  endsequence
  a_idle_quiet: assert property (selectPin_n |-> laneOe == 4'h0)
    else $error("lanes driven idle");
  a_lane_sets: assert property (laneOe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("bad lane set");
  a_cmd_late: assert property (s_end |-> (!cmdValid && !cmdDrop) [*3])
    else $error("command early");
  a_cmd_after: assert property (s_cmd |-> $past(selectPin_n, 2) && $past(selectPin_n, 3))
    else $error("command in frame");
  a_cmd_excl: assert property (cmdDrop |-> !cmdValid ##1 !cmdDrop)
    else $error("drop with accept");
  a_fetch_gap: assert property (fetchReq |=> !fetchReq [*8])
    else $error("fetch too close");
  a_latch_set: assert property ($rose(writeLatchFlag) |-> $past(selectPin_n, 3))
    else $error("latch set in frame");
  a_latch_clr: assert property ($fell(writeLatchFlag) |-> $past(cycleDone) || $past(selectPin_n, 3))
    else $error("latch cleared early");
endmodule : sfif_frontend_assertions
bind sfif_frontend sfif_frontend_assertions CHK (.clk, .arst_n, .selectPin_n, .laneOe, .fetchReq, .cmdValid,
  .cmdDrop, .cycleDone, .writeLatchFlag);

// [dv/sfif_host_model.sv]
// Host link model: select, clock and lanes.
`timescale 1ns/100ps
module sfif_host_model (
  // Link pins
  output logic            serialClk,
  output logic            selectPin_n,
  output logic [3:0]      laneIn,
  input  wire logic [3:0] laneOut,
  input  wire logic [3:0] laneOe
);
  logic [3:0] hostVal;
  logic [3:0] smp;
  // Wire level: device wins where it drives
  assign laneIn = (laneOe & laneOut) | (~laneOe & hostVal);
  initial begin
    serialClk   = 1'b0;
    selectPin_n = 1'b1;
    hostVal     = 4'h0;
  end
  task automatic tick(input logic [3:0] v);
    hostVal = v;
    #62.5 serialClk = 1'b1;
    smp = laneIn;
    #62.5 serialClk = 1'b0;
  endtask : tick
  task automatic send(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--)
      tick({3'h5, b[i]});
  endtask : send
  task automatic sendw(input logic [31:0] v, input int w, input int n);
    for (int i = 32 - w; i >= 32 - n; i -= w)
      tick(4'(v >> i) & 4'((1 << w) - 1));
  endtask : sendw
  task automatic open_frame();
    selectPin_n = 1'b0;
    #125;
  endtask : open_frame
  task automatic close_frame();
    #62.5 selectPin_n = 1'b1;
    hostVal = ~hostVal;
    #250;
  endtask : close_frame
endmodule : sfif_host_model

// [dv/sfif_frontend_bench.sv]
// Self-checking bench of the instruction front end.
`timescale 1ns/100ps
module sfif_frontend_bench;
  logic        clk, arst_n, serialClk, selectPin_n, busyIn, cycleDone, protectHit, fetchReq, fetchValid;
  logic        progValid, cmdValid, cmdVolatile, cmdDrop, writeLatchFlag, gotValid, gotDrop, seenOe, gotProg;
  logic [1:0]  statusWrBytes;
  logic [3:0]  laneIn, laneOut, laneOe;
  logic [7:0]  statusLowByte, statusHighByte, checkOp, fetchData, progByte, cmdOp, statusWrLow, statusWrHigh, rd;
  logic [23:0] checkAddr, fetchAddr, cmdAddr;
  int          mismatches, tests_run;
  sfif_frontend DUT (.clk, .arst_n, .serialClk, .selectPin_n, .laneIn, .laneOut, .laneOe, .statusLowByte,
    .statusHighByte, .busyIn, .cycleDone, .checkAddr, .checkOp, .protectHit, .fetchReq, .fetchAddr, .fetchData,
    .fetchValid, .progValid, .progByte, .cmdValid, .cmdOp, .cmdAddr, .cmdVolatile, .statusWrLow, .statusWrHigh,
    .statusWrBytes, .cmdDrop, .writeLatchFlag);
  sfif_host_model HOST (.serialClk, .selectPin_n, .laneIn, .laneOut, .laneOe);
  // 64KB block 0x3F (addresses 0x3F0000 to 0x3FFFFF) counts as protected
  assign protectHit = checkAddr[23:16] == 8'h3F;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) begin
    fetchValid <= fetchReq;
    fetchData  <= fetchAddr[7:0] ^ 8'hA5;
  end
  always @(posedge clk) begin
    if (cmdValid === 1'b1) gotValid <= 1'b1;
    if (cmdDrop === 1'b1) gotDrop <= 1'b1;
    if (laneOe !== 4'h0) seenOe <= 1'b1;
    if (progValid === 1'b1) gotProg <= 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input int n);
    gotValid = 1'b0;
    gotDrop = 1'b0;
    seenOe = 1'b0;
    gotProg = 1'b0;
    HOST.open_frame();
    HOST.send(op, 8);
    for (int i = 0; i < n; i++)
      HOST.send(a[31 - 8 * i -: 8], 8);
  endtask : frame
  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int n);
    frame(op, a, n);
    HOST.close_frame();
  endtask : cmd
  task automatic recv(input int w);
    for (int i = 0; i < 8 / w; i++) begin
      HOST.tick(4'h0);
      rd = (rd << w) | (8'(HOST.smp >> (w == 1)) & 8'((1 << w) - 1));
    end
  endtask : recv
  task automatic t_write();
    cmd(8'h06, 32'h0, 0);
    chk(writeLatchFlag, 1'b1);
    cmd(8'h20, 32'h01200000, 3);
    chk({gotValid, cmdOp, cmdAddr}, {1'b1, 8'h20, 24'h012000});
    cmd(8'h75, 32'h0, 0);
    chk({gotValid, cmdOp}, {1'b1, 8'h75});
    @(negedge clk) cycleDone = 1'b1;
    @(negedge clk) cycleDone = 1'b0;
    @(negedge clk);
    chk(writeLatchFlag, 1'b0);
    cmd(8'h52, 32'h01000000, 3);
    chk(gotDrop, 1'b1);
    cmd(8'h06, 32'h0, 0);
    cmd(8'hD8, 32'h3F000000, 3);
    chk(gotDrop, 1'b1);
    cmd(8'h06, 32'h0, 0);
    frame(8'h02, 32'h0001003C, 4);
    HOST.send(8'hFF, 4);
    HOST.close_frame();
    chk({gotDrop, progByte}, {1'b1, 8'h3C});
    cmd(8'h50, 32'h0, 0);
    cmd(8'h01, 32'h1C020000, 2);
    chk({gotValid, cmdVolatile, statusWrBytes, statusWrLow, statusWrHigh}, {2'h3, 2'h2, 16'h1C02});
    cmd(8'h06, 32'h0, 0);
    frame(8'h32, 32'h00020000, 3);
    HOST.sendw(32'h96000000, 4, 8);
    HOST.close_frame();
    chk({gotValid, gotProg, cmdOp, progByte}, {2'h3, 8'h32, 8'h96});
    cmd(8'h04, 32'h0, 0);
    chk(writeLatchFlag, 1'b0);
  endtask : t_write
  task automatic t_read();
    logic [7:0] ops [3] = '{8'h0B, 8'h3B, 8'h6B};
    frame(8'h03, 32'h00015500, 3);
    recv(1);
    chk({laneOe, rd}, {4'h2, 8'hF0});
    recv(1);
    chk(rd, 8'hF3);
    HOST.send(8'h00, 3);
    HOST.close_frame();
    chk(gotDrop, 1'b0);
    foreach (ops[k]) begin
      frame(ops[k], {24'h000200 + 24'(k), 8'h00}, 4);
      recv(1 << k);
      HOST.close_frame();
      chk(rd, 8'(k) ^ 8'hA5);
    end
  endtask : t_read
  task automatic t_io();
    logic [7:0] ops [4] = '{8'hBB, 8'hEB, 8'hE7, 8'hE3};
    int         dum [4] = '{0, 4, 2, 0};
    foreach (ops[k]) begin
      frame(ops[k], 32'h0, 0);
      HOST.sendw({16'h0003, 4'(k), 12'h000}, k ? 4 : 2, 32);
      repeat (dum[k]) HOST.tick(4'h0);
      recv(k ? 4 : 2);
      HOST.close_frame();
      chk(rd, {4'(k), 4'h0} ^ 8'hA5);
    end
  endtask : t_io
  task automatic t_busy();
    @(negedge clk);
    statusLowByte = 8'h5A;
    statusHighByte = 8'hC3;
    busyIn = 1'b1;
    for (int k = 0; k < 2; k++) begin
      frame(k ? 8'h35 : 8'h05, 32'h0, 0);
      repeat (2) begin
        recv(1);
        chk(rd, k ? 8'hC3 : 8'h5A);
      end
      HOST.close_frame();
    end
    frame(8'h03, 32'h00010000, 3);
    recv(1);
    HOST.close_frame();
    chk(seenOe, 1'b0);
    @(negedge clk) busyIn = 1'b0;
    frame(8'hFF, 32'hFFFFFFFF, 4);
    recv(1);
    HOST.close_frame();
    chk({seenOe, gotDrop}, 2'b00);
  endtask : t_busy
  task automatic close_out();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial begin
    arst_n = 1'b0;
    busyIn = 1'b0;
    cycleDone = 1'b0;
    fetchValid = 1'b0;
    fetchData = 8'h00;
    statusLowByte = 8'h00;
    statusHighByte = 8'h00;
    mismatches = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_write();
    t_read();
    t_io();
    t_busy();
    close_out();
  end
  initial begin
    #380000;
    mismatches++;
    close_out();
  end
endmodule : sfif_frontend_bench
